/* design/psd_pkg.sv */
/*
 pattern stimulus and delay offset: shared constants, types and helpers.
 assumes one 25 MHz clock and a plain word-wide register port.
*/
package psd_pkg;
    localparam int CLK_HZ      = 25000000;
    localparam int CLK_NS      = 1000000000 / CLK_HZ;
    localparam int NPIN        = 8;
    localparam int DEPTH       = 256;
    localparam int BURST_MS    = 10;
    localparam int BURST_CYC   = BURST_MS * (CLK_HZ / 1000);
    localparam int BURST_W     = 18;
    localparam int FREERUN_HZ  = 1000;
    localparam int FREERUN_CYC = CLK_HZ / FREERUN_HZ;
    localparam int FRC_W       = 15;
    localparam int STEP_NS     = 1000;
    localparam int STEP_CYC    = STEP_NS / CLK_NS;
    localparam int PULSE_NS    = 200;
    localparam int PULSE_CYC   = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SIG_W       = 16;
    localparam int TAP_MAX     = 63;
    localparam int PROBE_STEP_NS = 4;
    localparam int CLIP_STEP_NS  = 15;
    localparam logic [31:0] OFS_BIAS = 32'h000F4240;

    // register indexes on the plain port
    localparam logic [3:0] A_CTRL      = 4'h0;
    localparam logic [3:0] A_CMD       = 4'h1;
    localparam logic [3:0] A_PATPIN    = 4'h2;
    localparam logic [3:0] A_PATBIT    = 4'h3;
    localparam logic [3:0] A_STOPCNT   = 4'h4;
    localparam logic [3:0] A_STATUS    = 4'h5;
    localparam logic [3:0] A_PROBE_OFS = 4'h6;
    localparam logic [3:0] A_CLIP_OFS  = 4'h7;
    localparam logic [3:0] A_PROBE_SIG = 4'h8;
    localparam logic [3:0] A_CLIP_SIG  = 4'h9;

    // control field positions
    localparam int CTRL_SYNC_LSB = 0;
    localparam int CTRL_PM_LSB   = 2;
    localparam int CTRL_PEN      = 4;
    localparam int CTRL_MOD_LSB  = 5;

    // command codes in write data bits 2:0
    localparam logic [2:0] OP_HIZ    = 3'h1;
    localparam logic [2:0] OP_ERASE  = 3'h2;
    localparam logic [2:0] OP_APPLY  = 3'h3;
    localparam logic [2:0] OP_STROBE = 3'h4;

    // pattern depth per module count
    localparam logic [8:0] DEPTH_1 = 9'h0FF;
    localparam logic [8:0] DEPTH_2 = 9'h080;
    localparam logic [8:0] DEPTH_3 = 9'h055;
    localparam logic [8:0] DEPTH_4 = 9'h040;

    typedef enum logic [1:0] {SYNC_FREE, SYNC_INT, SYNC_POD, SYNC_EXT} psd_sync_t;
    typedef enum logic [1:0] {PM_HIGH, PM_LOW, PM_ALT} psd_pmode_t;
    typedef enum logic [1:0] {EX_IDLE, EX_WAIT, EX_RUN, EX_DONE} psd_ext_t;
    typedef logic [BURST_W-1:0] psd_btmr_t;
    typedef logic [FRC_W-1:0]   psd_frc_t;
    typedef logic [4:0]         psd_stc_t;
    typedef logic [2:0]         psd_pwc_t;

    // module count field (0 = one module) to pattern depth
    function automatic logic [8:0] psd_depth(input logic [1:0] mods);
        case (mods)
            2'h0: psd_depth = DEPTH_1;
            2'h1: psd_depth = DEPTH_2;
            2'h2: psd_depth = DEPTH_3;
            default: psd_depth = DEPTH_4;
        endcase
    endfunction
endpackage

/* design/psd_sig.sv */
/*
 signature register: 16-bit serial shift with feedback.
 assumes en and din are synchronous one-cycle qualifiers.
*/
`timescale 1ns/1ps
module psd_sig (
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic                     clr,
    input  wire logic                     en,
    input  wire logic                     din,
    output logic [psd_pkg::SIG_W-1:0]     sig
);
    typedef struct packed {
        logic [psd_pkg::SIG_W-1:0] s;
    } psd_sig_st_t;

    psd_sig_st_t r;
    psd_sig_st_t n;

    // shift the sampled bit into the feedback register
    always_comb begin
        n = r;
        if (clr) begin
            n.s = '0;
        end else if (en) begin
            n.s = {r.s[14:0], din ^ r.s[15] ^ r.s[11] ^ r.s[8] ^ r.s[6]};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign sig = r.s;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_SIG_HOLD: assert property (
        !en && !clr |=> $stable(sig))
        else $error("signature moved without an enable");
endmodule

/* design/psd_delay.sv */
/*
 delay offset store: one biased offset per sync mode, tap setting out.
 assumes wr is a one-cycle strobe beside wdata.
*/
`timescale 1ns/1ps
module psd_delay #(
    parameter int STEP_NS = 4
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        wr,
    input  wire logic [31:0] wdata,
    input  wire logic [1:0]  mode,
    output logic [31:0]      ofs_rd,
    output logic             ok,
    output logic [7:0]       tap
);
    typedef struct packed {
        logic [3:0][31:0] ofs;
        logic [3:0][7:0]  taps;
        logic             ok;
        logic [7:0]       tap;
    } psd_dly_st_t;

    psd_dly_st_t r;
    psd_dly_st_t n;

    // round to the nearest step, clamp, and store for the current mode
    always_comb begin
        int ns;
        int q;
        ns = 0;
        q = 0;
        n = r;
        n.tap = r.taps[mode];
        if (wr) begin
            ns = int'(wdata) - int'(psd_pkg::OFS_BIAS);
            if (ns >= 0) begin
                q = (ns + STEP_NS / 2) / STEP_NS;
            end else begin
                q = -((STEP_NS / 2 - ns) / STEP_NS);
            end
            n.ok = 1'b1;
            if (q > psd_pkg::TAP_MAX) begin
                q = psd_pkg::TAP_MAX;
                n.ok = 1'b0;
            end else if (q < -psd_pkg::TAP_MAX) begin
                q = -psd_pkg::TAP_MAX;
                n.ok = 1'b0;
            end
            n.ofs[mode] = psd_pkg::OFS_BIAS + 32'(q * STEP_NS);
            n.taps[mode] = 8'(q);
            n.tap = 8'(q);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            r.ofs <= {4{psd_pkg::OFS_BIAS}};
            r.taps <= '0;
            r.ok <= 1'b1;
            r.tap <= 8'h00;
        end else begin
            r <= n;
        end
    end

    assign ofs_rd = r.ofs[mode];
    assign ok = r.ok;
    assign tap = r.tap;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_OFS_CLAMP: assert property (
        wr && (int'(wdata) - int'(psd_pkg::OFS_BIAS) > (psd_pkg::TAP_MAX + 1) * STEP_NS)
        |=> !ok && tap == 8'(psd_pkg::TAP_MAX))
        else $error("out-of-range delay not clamped");

    AST_OFS_TAP: assert property (
        !wr |=> tap == r.taps[$past(mode)])
        else $error("tap does not follow the active mode");

    AST_OFS_MODE: assert property (
        !wr ##1 $stable(mode) |-> $stable(ofs_rd))
        else $error("offset changed without a write");

    AST_OFS_STEP: assert property (
        (int'(ofs_rd) - int'(psd_pkg::OFS_BIAS)) % STEP_NS == 0)
        else $error("stored offset off the step grid");
endmodule

/* design/psd_top.sv */
/*
 pattern stimulus and delay offset block: pattern driver for the clip pins,
 probe pulser with its sync sources, signatures and per-mode delay offsets.
 assumes all inputs are synchronous to clk and a plain register port.
*/
`timescale 1ns/1ps
module psd_top #(
    parameter int BURST_CYC   = psd_pkg::BURST_CYC,
    parameter int FREERUN_CYC = psd_pkg::FREERUN_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic [7:0]  pin_in,
    output logic [7:0]       pin_out,
    output logic [7:0]       pin_oe,
    input  wire logic        pod_sync_strobe_b,
    input  wire logic        ext_start,
    input  wire logic        ext_stop,
    input  wire logic        ext_clk,
    input  wire logic        ext_enable,
    input  wire logic        probe_in,
    output logic             probe_out,
    output logic             probe_oe,
    output logic [7:0]       probe_tap,
    output logic [7:0]       clip_tap
);
    typedef struct packed {
        psd_pkg::psd_sync_t  sync;
        psd_pkg::psd_pmode_t pmode;
        logic                pen;
        logic [1:0]          mods;
        logic [15:0]         stopcnt;
        logic [7:0][255:0]   pat;
        logic [7:0]          lmask;
        logic [2:0]          wpin;
        logic [7:0]          wpos;
        logic [7:0]          len;
        logic                act;
        logic                tmo;
        logic [7:0]          pos;
        psd_pkg::psd_btmr_t  btmr;
        psd_pkg::psd_stc_t   stc;
        logic [7:0]          pout;
        logic [7:0]          poe;
        psd_pkg::psd_frc_t   frc;
        logic                pod_q;
        logic                xclk_q;
        logic                xstart_q;
        logic                xstop_q;
        psd_pkg::psd_ext_t   ext;
        logic [15:0]         xcnt;
        psd_pkg::psd_pwc_t   pwc;
        logic                alt;
        logic                prb_o;
        logic                prb_oe;
        logic [31:0]         rdata;
    } psd_st_t;

    psd_st_t r;
    psd_st_t n;

    logic                      cmd_wr;
    logic                      se;
    logic                      step;
    logic                      last;
    logic [8:0]                depth;
    logic                      pr_wr;
    logic                      cl_wr;
    logic                      pr_clr;
    logic                      cl_en;
    logic [31:0]               pr_ofs;
    logic [31:0]               cl_ofs;
    logic                      pr_ok;
    logic                      cl_ok;
    logic [psd_pkg::SIG_W-1:0] pr_sig;
    logic [psd_pkg::SIG_W-1:0] cl_sig;

    // decode strobes shared by several parts
    assign cmd_wr = reg_wr && reg_addr == psd_pkg::A_CMD;
    assign pr_wr  = reg_wr && reg_addr == psd_pkg::A_PROBE_OFS;
    assign cl_wr  = reg_wr && reg_addr == psd_pkg::A_CLIP_OFS;
    assign depth  = psd_pkg::psd_depth(r.mods);
    assign step   = r.act && r.stc == psd_pkg::psd_stc_t'(psd_pkg::STEP_CYC - 1);
    assign last   = (r.pos + 8'h01 == r.len) || ({1'b0, r.pos} + 9'h001 >= depth);
    assign pr_clr = reg_wr && reg_addr == psd_pkg::A_CTRL
                    && reg_wdata[psd_pkg::CTRL_PEN] && !r.pen;
    assign cl_en  = step && r.sync == psd_pkg::SYNC_INT;

    // sync event for the pulser, chosen by the sync mode
    always_comb begin
        case (r.sync)
            psd_pkg::SYNC_FREE: se = r.frc == psd_pkg::psd_frc_t'(FREERUN_CYC - 1);
            psd_pkg::SYNC_INT:  se = cmd_wr && reg_wdata[2:0] == psd_pkg::OP_STROBE;
            psd_pkg::SYNC_POD:  se = pod_sync_strobe_b && !r.pod_q;
            psd_pkg::SYNC_EXT:  se = r.ext == psd_pkg::EX_RUN && ext_clk && !r.xclk_q
                                     && ext_enable;
            default:            se = 1'b0;
        endcase
    end

    // next state of the whole block
    always_comb begin
        n = r;
        n.rdata = '0;
        n.pod_q = pod_sync_strobe_b;
        n.xclk_q = ext_clk;
        n.xstart_q = ext_start;
        n.xstop_q = ext_stop;

        // free-running divider for the 1 kHz source
        if (r.frc == psd_pkg::psd_frc_t'(FREERUN_CYC - 1)) begin
            n.frc = '0;
        end else begin
            n.frc = r.frc + 1'b1;
        end

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                psd_pkg::A_CTRL: begin
                    n.sync = psd_pkg::psd_sync_t'(reg_wdata[psd_pkg::CTRL_SYNC_LSB +: 2]);
                    n.pmode = psd_pkg::psd_pmode_t'(reg_wdata[psd_pkg::CTRL_PM_LSB +: 2]);
                    n.pen = reg_wdata[psd_pkg::CTRL_PEN];
                    n.mods = reg_wdata[psd_pkg::CTRL_MOD_LSB +: 2];
                end
                psd_pkg::A_STOPCNT: n.stopcnt = reg_wdata[15:0];
                psd_pkg::A_PATPIN: begin
                    n.wpin = reg_wdata[2:0];
                    n.wpos = 8'h00;
                end
                psd_pkg::A_PATBIT: begin
                    if ({1'b0, r.wpos} < depth) begin
                        n.pat[r.wpin][r.wpos] = reg_wdata[0];
                        n.lmask[r.wpin] = 1'b1;
                        n.wpos = r.wpos + 8'h01;
                        if (r.wpos >= r.len) begin
                            n.len = r.wpos + 8'h01;
                        end
                    end
                end
                default: ;
            endcase
        end

        // burst in progress: time limit, then step through positions
        if (r.act) begin
            n.btmr = r.btmr + 1'b1;
            if (r.btmr >= psd_pkg::psd_btmr_t'(BURST_CYC - 1)) begin
                n.act = 1'b0;
                n.tmo = 1'b1;
                n.poe = 8'h00;
            end else if (step) begin
                n.stc = '0;
                if (last) begin
                    n.act = 1'b0;
                    n.poe = 8'h00;
                end else begin
                    n.pos = r.pos + 8'h01;
                    for (int i = 0; i < psd_pkg::NPIN; i++) begin
                        n.pout[i] = r.pat[i][r.pos + 8'h01];
                    end
                end
            end else begin
                n.stc = r.stc + 1'b1;
            end
        end

        // apply starts a burst in any sync mode
        if (cmd_wr && reg_wdata[2:0] == psd_pkg::OP_APPLY && r.len != 8'h00) begin
            n.act = 1'b1;
            n.tmo = 1'b0;
            n.pos = 8'h00;
            n.btmr = '0;
            n.stc = '0;
            n.poe = r.lmask;
            for (int i = 0; i < psd_pkg::NPIN; i++) begin
                n.pout[i] = r.pat[i][0];
            end
        end

        // tristate and erase stop any burst
        if (cmd_wr && reg_wdata[2:0] == psd_pkg::OP_HIZ) begin
            n.act = 1'b0;
            n.poe = 8'h00;
        end
        if (cmd_wr && reg_wdata[2:0] == psd_pkg::OP_ERASE) begin
            n.act = 1'b0;
            n.poe = 8'h00;
            n.len = 8'h00;
            n.lmask = 8'h00;
            n.wpos = 8'h00;
        end

        // external sync gating: wait for start, run to stop or count
        case (r.ext)
            psd_pkg::EX_IDLE: begin
                if (r.pen && r.sync == psd_pkg::SYNC_EXT) begin
                    n.ext = psd_pkg::EX_WAIT;
                end
            end
            psd_pkg::EX_WAIT: begin
                if (ext_start && !r.xstart_q) begin
                    n.ext = psd_pkg::EX_RUN;
                    n.xcnt = 16'h0000;
                end
            end
            psd_pkg::EX_RUN: begin
                if (se) begin
                    n.xcnt = r.xcnt + 16'h0001;
                end
                if (r.stopcnt != 16'h0000) begin
                    if (se && r.xcnt + 16'h0001 == r.stopcnt) begin
                        n.ext = psd_pkg::EX_DONE;
                    end
                end else if (ext_stop && !r.xstop_q) begin
                    n.ext = psd_pkg::EX_DONE;
                end
            end
            psd_pkg::EX_DONE: ;
            default: n.ext = psd_pkg::EX_IDLE;
        endcase
        if (!n.pen || n.sync != psd_pkg::SYNC_EXT) begin
            n.ext = psd_pkg::EX_IDLE;
        end

        // pulser: a pulse of fixed width on each sync event
        if (r.prb_oe) begin
            if (r.pwc == '0) begin
                n.prb_oe = 1'b0;
            end else begin
                n.pwc = r.pwc - 1'b1;
            end
        end
        if (r.pen && se) begin
            n.prb_oe = 1'b1;
            n.pwc = psd_pkg::psd_pwc_t'(psd_pkg::PULSE_CYC - 1);
            case (r.pmode)
                psd_pkg::PM_LOW: n.prb_o = 1'b0;
                psd_pkg::PM_ALT: begin
                    n.prb_o = r.alt;
                    n.alt = !r.alt;
                end
                default: n.prb_o = 1'b1;
            endcase
        end
        if (!n.pen) begin
            n.prb_oe = 1'b0;
        end

        // read data stands in the cycle after the read strobe
        if (reg_rd) begin
            case (reg_addr)
                psd_pkg::A_CTRL:      n.rdata = {25'h0, r.mods, r.pen, r.pmode, r.sync};
                psd_pkg::A_STOPCNT:   n.rdata = {16'h0, r.stopcnt};
                psd_pkg::A_STATUS:    n.rdata = {16'h0, r.len, 2'h0, r.ext,
                                                 cl_ok, pr_ok, r.tmo, r.act};
                psd_pkg::A_PROBE_OFS: n.rdata = pr_ofs;
                psd_pkg::A_CLIP_OFS:  n.rdata = cl_ofs;
                psd_pkg::A_PROBE_SIG: n.rdata = {16'h0, pr_sig};
                psd_pkg::A_CLIP_SIG:  n.rdata = {16'h0, cl_sig};
                default:              n.rdata = '0;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            r <= '0;
            r.pod_q <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign reg_rdata = r.rdata;
    assign pin_out   = r.pout;
    assign pin_oe    = r.poe;
    assign probe_out = r.prb_o;
    assign probe_oe  = r.prb_oe;

    // probe signature runs on pulser events
    psd_sig u_prb_sig (
        .clk   (clk),
        .rst_b (rst_b),
        .clr   (pr_clr),
        .en    (r.pen && se),
        .din   (probe_in),
        .sig   (pr_sig)
    );

    // clip signature folds all pins at each pattern step under internal sync
    psd_sig u_clp_sig (
        .clk   (clk),
        .rst_b (rst_b),
        .clr   (cmd_wr && reg_wdata[2:0] == psd_pkg::OP_APPLY),
        .en    (cl_en),
        .din   (^pin_in),
        .sig   (cl_sig)
    );

    // probe delay line offsets, one per sync mode
    psd_delay #(
        .STEP_NS (psd_pkg::PROBE_STEP_NS)
    ) u_prb_dly (
        .clk    (clk),
        .rst_b  (rst_b),
        .wr     (pr_wr),
        .wdata  (reg_wdata),
        .mode   (r.sync),
        .ofs_rd (pr_ofs),
        .ok     (pr_ok),
        .tap    (probe_tap)
    );

    // clip delay line offsets, one per sync mode
    psd_delay #(
        .STEP_NS (psd_pkg::CLIP_STEP_NS)
    ) u_clp_dly (
        .clk    (clk),
        .rst_b  (rst_b),
        .wr     (cl_wr),
        .wdata  (reg_wdata),
        .mode   (r.sync),
        .ofs_rd (cl_ofs),
        .ok     (cl_ok),
        .tap    (clip_tap)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_BURST_LIMIT: assert property (
        r.act |-> r.btmr < psd_pkg::psd_btmr_t'(BURST_CYC))
        else $error("burst outlived its time limit");

    AST_APPLY_ANY: assert property (
        cmd_wr && reg_wdata[2:0] == psd_pkg::OP_APPLY && r.len != 8'h00 |=> r.act)
        else $error("apply did not start a burst");

    AST_TRISTATE: assert property (
        cmd_wr && reg_wdata[2:0] == psd_pkg::OP_HIZ |=> pin_oe == 8'h00 && !r.act)
        else $error("tristate left a pin driven");

    AST_ERASE: assert property (
        cmd_wr && reg_wdata[2:0] == psd_pkg::OP_ERASE |=> r.len == 8'h00 ##1 !r.act)
        else $error("erase kept a pattern");

    AST_DEPTH: assert property (
        r.act |-> {1'b0, r.pos} < depth)
        else $error("burst passed the depth limit");

    AST_POD_LOW: assert property (
        r.pen && r.sync == psd_pkg::SYNC_POD && r.pmode == psd_pkg::PM_LOW
        && pod_sync_strobe_b && !r.pod_q && !reg_wr |=> probe_oe && !probe_out)
        else $error("no low pulse on strobe rising edge");

    AST_EXT_STOP: assert property (
        r.ext == psd_pkg::EX_RUN && r.stopcnt == 16'h0000 && ext_stop && !r.xstop_q
        |=> r.ext != psd_pkg::EX_RUN)
        else $error("external run ignored stop");

    AST_STEP_ORDER: assert property (
        r.act && step && !last && !cmd_wr && r.btmr < psd_pkg::psd_btmr_t'(BURST_CYC - 1)
        |=> r.pos == $past(r.pos) + 8'h01)
        else $error("pattern position skipped");

    AST_END_HIZ: assert property (
        $fell(r.act) |-> pin_oe == 8'h00)
        else $error("pins still driven after burst");

    COV_BURST_DONE: cover property (r.act && step && last);
    COV_POD_PULSE: cover property (r.sync == psd_pkg::SYNC_POD && r.pen && se);
    COV_EXT_DONE: cover property (r.ext == psd_pkg::EX_RUN ##1 r.ext == psd_pkg::EX_DONE);
    COV_CLAMP: cover property (pr_wr ##1 !pr_ok);
endmodule

/* bench/psd_uut_model.sv */
/*
 far side model: pins of the clipped part and the probed node.
 assumes the enables are high while the block drives a pin.
*/
`timescale 1ns/1ps
module psd_uut_model (
    input  wire logic       clk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic       probe_out,
    input  wire logic       probe_oe,
    output logic [7:0]      pin_in,
    output logic            probe_in
);
    logic [8:0] last_r = 9'h000;
    // released nodes float: show the inverse of the last level seen
    always_ff @(posedge clk) last_r <= {probe_in, pin_in};
    assign pin_in   = (pin_oe & pin_out) | (~pin_oe & ~last_r[7:0]);
    assign probe_in = probe_oe ? probe_out : ~last_r[8];
endmodule

/* bench/psd_tb.sv */
/*
 testbench: register tasks and hand-written scenarios for the block.
 assumes the far side model and a shortened burst time limit.
*/
`timescale 1ns/1ps
module pattern_stimulus_and_delay_offset_tb_top;
    logic        clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        strb_b = 1'b1, probe_out, probe_oe, probe_in;
    logic        ext_start = 1'b0, ext_stop = 1'b0, ext_clk = 1'b0, ext_en = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic [7:0]  pin_in, pin_out, pin_oe, probe_tap, clip_tap;
    int          fails = 0, comparisons = 0, cycles = 0;
    // clock and hang limit
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end
    psd_top #(.BURST_CYC(300), .FREERUN_CYC(40)) i_dut (.clk(clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pod_sync_strobe_b(strb_b), .ext_start(ext_start), .ext_stop(ext_stop),
        .ext_clk(ext_clk), .ext_enable(ext_en), .probe_in(probe_in), .probe_out(probe_out),
        .probe_oe(probe_oe), .probe_tap(probe_tap), .clip_tap(clip_tap));
    psd_uut_model i_uut (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .probe_out(probe_out), .probe_oe(probe_oe), .pin_in(pin_in), .probe_in(probe_in));
    // register port cycles
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    // two pins stepping in lockstep, under internal sync so the clip signature runs
    task automatic t_burst();
        wr(4'h0, 32'h1);
        wr(4'h2, 32'h0);
        wr(4'h3, 32'h1);
        wr(4'h3, 32'h0);
        wr(4'h2, 32'h5);
        wr(4'h3, 32'h0);
        wr(4'h3, 32'h1);
        wr(4'h1, 32'h3);
        cyc(5);
        chk({pin_oe, pin_out}, 32'h2101, "step 0");
        cyc(25);
        chk({pin_oe, pin_out}, 32'h2120, "step 1");
        cyc(30);
        chk(pin_oe, 32'h0, "release");
        rd(4'h9);
        chk(d, 32'h3, "clip signature");
        $display("burst done");
    endtask
    // four modules: depth cap, time limit, tristate, erase
    task automatic t_limit();
        wr(4'h0, 32'h60);
        wr(4'h1, 32'h2);
        wr(4'h2, 32'h0);
        repeat (70) wr(4'h3, 32'h1);
        rd(4'h5);
        chk(d[15:8], 32'h40, "depth");
        wr(4'h1, 32'h3);
        cyc(290);
        chk(pin_oe, 32'h1, "early drop");
        cyc(20);
        chk(pin_oe, 32'h0, "limit");
        rd(4'h5);
        chk(d[1:0], 32'h2, "limit flag");
        wr(4'h1, 32'h3);
        cyc(5);
        wr(4'h1, 32'h1);
        cyc(2);
        chk(pin_oe, 32'h0, "tristate");
        wr(4'h1, 32'h2);
        wr(4'h1, 32'h3);
        rd(4'h5);
        chk({d[15:8], pin_oe}, 32'h0, "erase");
        $display("limit done");
    endtask
    // pod strobe low pulse, then software strobe high pulse
    task automatic t_pulse();
        wr(4'h0, 32'h16);
        strb_b <= 1'b0;
        @(posedge clk);
        strb_b <= 1'b1;
        cyc(3);
        chk({probe_oe, probe_out}, 32'h2, "pod low");
        cyc(8);
        chk(probe_oe, 32'h0, "pulse end");
        wr(4'h0, 32'h11);
        wr(4'h1, 32'h4);
        cyc(3);
        chk({probe_oe, probe_out}, 32'h3, "strobe high");
        $display("pulse done");
    endtask
    // one external clock rise, then wait with the pulse in flight
    task automatic xclk();
        @(posedge clk);
        ext_clk <= 1'b1;
        @(posedge clk);
        ext_clk <= 1'b0;
        cyc(3);
    endtask
    // external sync: start, stop edge, then stop count, alternating pulses
    task automatic t_ext();
        wr(4'h0, 32'h1B);
        repeat (2) @(posedge clk);
        ext_start <= 1'b1;
        ext_en <= 1'b1;
        xclk();
        chk({probe_oe, probe_out}, 32'h2, "alt first");
        @(posedge clk);
        ext_stop <= 1'b1;
        xclk();
        chk(probe_oe, 32'h0, "stop edge");
        wr(4'h4, 32'h2);
        wr(4'h0, 32'h8);
        ext_start <= 1'b0;
        ext_stop <= 1'b0;
        wr(4'h0, 32'h1B);
        repeat (2) @(posedge clk);
        ext_start <= 1'b1;
        xclk();
        chk({probe_oe, probe_out}, 32'h3, "alt second");
        xclk();
        chk({probe_oe, probe_out}, 32'h2, "count pulse");
        xclk();
        chk(probe_oe, 32'h0, "stop count");
        rd(4'h5);
        chk(d[5:4], 32'h3, "ext done");
        $display("ext done");
    endtask
    // per-mode biased offsets, rounding and clamping
    task automatic t_ofs();
        wr(4'h0, 32'h3);
        wr(4'h6, 32'h000F4222);
        cyc(2);
        chk(probe_tap, 32'hF8, "probe tap");
        rd(4'h6);
        chk(d, 32'h000F4220, "probe ofs");
        wr(4'h0, 32'h0);
        cyc(2);
        chk(probe_tap, 32'h0, "mode tap");
        rd(4'h6);
        chk(d, 32'h000F4240, "free ofs");
        wr(4'h7, 32'h000F4A10);
        rd(4'h5);
        chk(d[3:2], 32'h1, "ok flags");
        chk(clip_tap, 32'h3F, "clamp");
        rd(4'hF);
        chk(d, 32'h0, "unmapped");
        $display("offset done");
    endtask
    task automatic close_out();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // reset, then the scenarios
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_burst();
        t_limit();
        t_pulse();
        t_ext();
        t_ofs();
        close_out();
    end
endmodule
